// ==== testbench.sv ====
`timescale 1ns/1ps
// Call timing bench
module testbench;
  localparam int MS = 4; // Cycles per millisecond in simulation
  localparam int TENTH = MS * 100; // Cycles per tenth second
  localparam int SEC = MS * 1000; // Cycles per second
  logic i_clk, i_rstn, i_hsel, i_hwrite, o_hreadyout, o_hresp;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd, seed;
  logic [1:0] i_htrans;
  logic i_occupied, green_req, i_phase_green, i_loop_fail;
  logic [11:0] i_induct_uh;
  logic [7:0] i_dll_pct;
  logic o_call, o_osc_en, o_auto_reset, o_retune;
  logic [3:0] o_sens_level;
  logic [2:0] o_freq_sel;
  int rises, last_len, mismatches, compares, resets, n, r0;
  int q[$]; // Inductance values to show

  vlct_top #(.MS_CYC(MS)) u_vlct_top (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_occupied(i_occupied), .i_phase_green(i_phase_green),
    .i_loop_fail(i_loop_fail), .i_induct_uh(i_induct_uh), .i_dll_pct(i_dll_pct),
    .o_call(o_call), .o_osc_en(o_osc_en), .o_sens_level(o_sens_level),
    .o_freq_sel(o_freq_sel), .o_auto_reset(o_auto_reset), .o_retune(o_retune)
  );
  vlct_ctrl_model u_vlct_ctrl_model (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_call(o_call), .i_green_req(green_req),
    .o_phase_green(i_phase_green), .o_rises(rises), .o_last_len(last_len)
  );

  // Free-running clock, 100 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Counts detector reset pulses
  always @(posedge i_clk)
  begin
    if (o_auto_reset === 1'b1)
      resets++;
  end

  // Xorshift
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One AHB-Lite single transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {24'h0, a};
    i_hwrite <= wr;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask

  task automatic waitc(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  // Bounded wait for a call level
  task automatic wait_call(input logic v, input int lim);
    n = 0;
    while (o_call !== v && n < lim)
    begin
      @(posedge i_clk);
      n++;
    end
  endtask

  // Prints counts and verdict, ends the run
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (90000) @(posedge i_clk);
    mismatches++;
    results();
  end

  // Main sequence
  initial
  begin
    {i_rstn, i_hsel, i_hwrite, i_occupied, green_req, i_loop_fail} = 6'h0;
    {i_haddr, i_hwdata, i_htrans, i_induct_uh, i_dll_pct} = 86'h0;
    seed = 32'h0000_9CEE;
    waitc(6);
    i_rstn <= 1'b1;
    waitc(2);
    bus(0, vlct_pkg::A_CTRL, 0);
    chk("ctrl_rst", rd, 32'h4);
    bus(1, 8'h20, 32'hFFFF_FFFF);
    bus(0, 8'h20, 0);
    chk("unmapped", rd, 32'h0);
    // Every level and frequency code
    for (int i = 0; i < 9; i++)
    begin
      bus(1, vlct_pkg::A_CTRL, 32'(i | ((i % 8) << 4)));
      waitc(3);
      chk("sens", 32'(o_sens_level), 32'(i));
      chk("freq", 32'(o_freq_sel), 32'(i % 8));
    end
    // Forced states ignore a random occupancy
    for (int s = 9; s < 11; s++)
    begin
      bus(1, vlct_pkg::A_CTRL, 32'(s));
      i_occupied <= 1'(xs() >> 3);
      waitc(8);
      chk("forced_call", 32'(o_call), 32'(s == 9));
      chk("osc_off", 32'(o_osc_en), 32'h0);
    end
    bus(1, vlct_pkg::A_CTRL, 32'hB);
    waitc(3);
    chk("sens_keep", 32'(o_sens_level), 32'hA);
    i_occupied <= 1'b0;
    bus(1, vlct_pkg::A_CTRL, 32'h4);
    bus(1, vlct_pkg::A_DELAY, 32'h2);
    bus(1, vlct_pkg::A_EXT, 32'h0);
    // Two second delay withholds, then calls
    i_occupied <= 1'b1;
    waitc(SEC - 100);
    chk("delay_hold", 32'(o_call), 32'h0);
    wait_call(1, SEC + 200);
    chk("delay_done", 32'(o_call), 32'h1);
    i_occupied <= 1'b0;
    wait_call(0, 5);
    chk("clear", 32'(o_call), 32'h0);
    // Green aborts a long delay
    bus(1, vlct_pkg::A_DELAY, 32'hC8);
    i_occupied <= 1'b1;
    waitc(50);
    chk("delay_wait", 32'(o_call), 32'h0);
    green_req <= 1'b1;
    wait_call(1, 6);
    chk("green_abort", 32'(o_call), 32'h1);
    bus(0, vlct_pkg::A_STAT, 0);
    chk("delay_rem", 32'(rd[23:16]), 32'h0);
    i_occupied <= 1'b0;
    green_req <= 1'b0;
    bus(1, vlct_pkg::A_DELAY, 32'h0);
    bus(1, vlct_pkg::A_EXT, 32'h5);
    // Half second extension, reloaded
    i_occupied <= 1'b1;
    waitc(10);
    i_occupied <= 1'b0;
    waitc(4 * TENTH - 100);
    chk("ext_hold", 32'(o_call), 32'h1);
    i_occupied <= 1'b1;
    waitc(10);
    i_occupied <= 1'b0;
    waitc(4 * TENTH - 100);
    chk("ext_reload", 32'(o_call), 32'h1);
    wait_call(0, 2 * TENTH);
    chk("ext_end", 32'(o_call), 32'h0);
    // Gating on without green: no extension
    bus(1, vlct_pkg::A_CTRL, 32'h204);
    i_occupied <= 1'b1;
    waitc(10);
    i_occupied <= 1'b0;
    wait_call(0, 6);
    chk("gate", 32'(o_call), 32'h0);
    bus(1, vlct_pkg::A_EXT, 32'h0);
    // Pulse mode
    bus(1, vlct_pkg::A_CTRL, 32'h104);
    i_occupied <= 1'b1;
    wait_call(1, 5);
    wait_call(0, 200 * MS);
    waitc(2);
    chk("pulse_len", 32'(last_len >= 115 * MS && last_len <= 135 * MS), 32'h1);
    n = 0;
    while (o_retune !== 1'b1 && n < 3 * SEC)
    begin
      @(posedge i_clk);
      n++;
    end
    n = n + 125 * MS;
    chk("tune_out", 32'(n > 19 * TENTH && n < 21 * TENTH), 32'h1);
    r0 = rises;
    i_occupied <= 1'b0;
    waitc(2 * TENTH);
    i_occupied <= 1'b1;
    wait_call(1, 2 * TENTH);
    waitc(2);
    chk("resense", 32'(rises), 32'(r0 + 1));
    i_occupied <= 1'b0;
    wait_call(0, 200 * MS);
    // Max presence of two seconds, no end sync
    bus(1, vlct_pkg::A_CTRL, 32'h4);
    bus(1, vlct_pkg::A_MAXP, 32'h2);
    r0 = resets;
    i_occupied <= 1'b1;
    wait_call(1, 5);
    n = 0;
    while (resets == r0 && n < 3 * SEC)
    begin
      @(posedge i_clk);
      n++;
    end
    chk("maxp_time", 32'(n > SEC - 10 && n <= 2 * SEC + 10), 32'h1);
    waitc(5);
    chk("maxp_drop", 32'(o_call), 32'h0);
    i_occupied <= 1'b0;
    waitc(5);
    r0 = resets;
    i_occupied <= 1'b1;
    waitc(SEC / 2);
    i_occupied <= 1'b0;
    waitc(2 * SEC + 100);
    chk("no_reset", 32'(resets), 32'(r0));
    // End sync only with max presence on
    bus(1, vlct_pkg::A_MAXP, 32'h0);
    bus(1, vlct_pkg::A_CTRL, 32'h404);
    bus(0, vlct_pkg::A_CTRL, 0);
    chk("sync_off", rd, 32'h4);
    bus(1, vlct_pkg::A_MAXP, 32'h2);
    bus(1, vlct_pkg::A_CTRL, 32'h404);
    bus(0, vlct_pkg::A_CTRL, 0);
    chk("sync_on", rd, 32'h404);
    green_req <= 1'b1;
    waitc(5);
    i_occupied <= 1'b1;
    waitc(2 * SEC + 200);
    bus(0, vlct_pkg::A_STAT, 0);
    chk("wait_state", 32'(rd[4:0]), 32'h10);
    chk("wait_call", 32'(o_call), 32'h1);
    r0 = resets;
    i_loop_fail <= 1'b1;
    green_req <= 1'b0;
    waitc(20);
    chk("fail_hold", 32'(resets), 32'(r0));
    i_loop_fail <= 1'b0;
    green_req <= 1'b1;
    waitc(5);
    green_req <= 1'b0;
    waitc(10);
    chk("eog_reset", 32'(resets), 32'(r0 + 1));
    i_occupied <= 1'b0;
    // Inductance display range
    bus(1, vlct_pkg::A_DIAG, 32'h1);
    q = {19, 20, 2500, 2501};
    repeat (4) q.push_back(int'(xs() & 32'hFFF));
    foreach (q[i])
    begin
      i_induct_uh <= 12'(q[i]);
      i_dll_pct <= 8'(xs());
      waitc(3);
      bus(0, vlct_pkg::A_DISP, 0);
      chk("induct", 32'(rd[11:0]), 32'((q[i] >= 20 && q[i] <= 2500) ? q[i] : 0));
    end
    results();
  end
endmodule

// ==== vlct_ctrl_model.sv ====
`timescale 1ns/1ps
// Signal controller stand-in
module vlct_ctrl_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_call,
  input wire logic i_green_req,
  output logic o_phase_green,
  output int o_rises,
  output int o_last_len
);
  int run; // Cycles the current call has stood

  // Green follows the request a cycle later
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_phase_green <= 1'b0;
    end
    else
    begin
      o_phase_green <= i_green_req;
    end
  end

  // Call onsets and last call length
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      run <= 0;
      o_rises <= 0;
      o_last_len <= 0;
    end
    else if (i_call)
    begin
      run <= run + 1;
      if (run == 0)
      begin
        o_rises <= o_rises + 1;
      end
    end
    else if (run != 0)
    begin
      o_last_len <= run;
      run <= 0;
    end
  end
endmodule

// ==== vlct_pkg.sv ====
package vlct_pkg;
  // Clock rate and derived tick periods
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned T_MS_US = 1000;
  localparam int unsigned MS_CYC = CLK_HZ / 1_000_000 * T_MS_US;
  localparam int unsigned T_TENTH_MS = 100;
  localparam int unsigned T_SEC_TENTHS = 10;
  // Timing figures in their own units
  localparam int unsigned T_PULSE_MS = 125;
  localparam int unsigned T_TUNE_S = 2;
  localparam int unsigned T_PEAK_S = 2;
  localparam int unsigned T_DIAG_MIN = 15;
  // Derived counts
  localparam logic [7:0] PULSE_CNT = 8'(T_PULSE_MS);
  localparam logic [4:0] TUNE_CNT = 5'(T_TUNE_S * T_SEC_TENTHS);
  localparam logic [4:0] PEAK_CNT = 5'(T_PEAK_S * T_SEC_TENTHS);
  localparam logic [9:0] DIAG_CNT = 10'(T_DIAG_MIN * 60);
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DELAY = 8'h04;
  localparam logic [7:0] A_EXT = 8'h08;
  localparam logic [7:0] A_MAXP = 8'h0C;
  localparam logic [7:0] A_DIAG = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_TIMER = 8'h18;
  localparam logic [7:0] A_DISP = 8'h1C;
  // Control field positions
  localparam int unsigned F_SENS = 0;
  localparam int unsigned F_FREQ = 4;
  localparam int unsigned F_PULSE = 8;
  localparam int unsigned F_GATE = 9;
  localparam int unsigned F_SYNC = 10;
  // Sensitivity codes: 0..8 levels, then forced states
  localparam logic [3:0] SENS_FORCE = 4'h9;
  localparam logic [3:0] SENS_OFF = 4'hA;
  // Reset values and limits
  localparam logic [3:0] RST_SENS = 4'h4;
  localparam logic [2:0] RST_FREQ = 3'h0;
  localparam logic [9:0] MAXP_LIM = 10'h3E7;
  localparam logic [11:0] IND_MIN = 12'h014;
  localparam logic [11:0] IND_MAX = 12'h9C4;
  // Call timing states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DELAY = 5'h02,
    ST_DETECT = 5'h04,
    ST_EXTEND = 5'h08,
    ST_WAIT = 5'h10
  } vlct_state_e;
endpackage

// ==== vlct_top.sv ====
`timescale 1ns/1ps
// How it works
// - Forced-call setting: output Call, oscillator off
// - Channel-off setting: output No-Call, oscillator off
// - Nine levels, two forced settings, eight frequencies
// - Call delay 0 to 255 seconds
// - Delay starts on entry, call withheld meanwhile
// - Phase green aborts delay, remaining time zero
// - Extension 0 to 25.5 s, starts on clear
// - Entry during extension returns to detect, reload
// - Presence or pulse mode; presence holds call
// - Pulse mode: one 125 ms pulse per vehicle
// - Pulse mode: tune out after two seconds
// - Pulse mode: full sensitivity soon after leaving
// - Max presence 1 to 999 s or off
// - Loop empties before expiry: drop, no reset
// - Expiry without end sync: automatic reset
// - Expiry with end sync: wait, then drop or reset
// - End sync only usable with max presence on
// - Loop failure blocks end-of-green reset
// - Inductance display, range checked, 15 minute timeout
// - Change display holds peak for two seconds
// - Extension gating: extend only during phase green
module vlct_top #(
  parameter int unsigned MS_CYC = vlct_pkg::MS_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_occupied,
  input wire logic i_phase_green,
  input wire logic i_loop_fail,
  input wire logic [11:0] i_induct_uh,
  input wire logic [7:0] i_dll_pct,
  output logic o_call,
  output logic o_osc_en,
  output logic [3:0] o_sens_level,
  output logic [2:0] o_freq_sel,
  output logic o_auto_reset,
  output logic o_retune
);

  localparam int unsigned MSW = $clog2(MS_CYC + 1);

  // Tick divider state
  logic [MSW-1:0] ms_cnt_q;
  logic [6:0] tenth_cnt_q;
  logic [3:0] sec_cnt_q;
  logic tick_ms_q;
  logic tick_t_q;
  logic tick_s_q;

  // Configuration registers
  logic [3:0] sens_q;
  logic [2:0] freq_q;
  logic pulse_q;
  logic gate_q;
  logic sync_q;
  logic [7:0] delay_q;
  logic [7:0] ext_q;
  logic [9:0] maxp_q;
  logic cfg_rst_q;

  // Bus pipeline
  logic wr_q;
  logic [7:0] adr_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic acc;
  logic wr_act;

  // Call timing state
  vlct_pkg::vlct_state_e state_q;
  logic [7:0] delay_rem_q;
  logic [7:0] ext_rem_q;
  logic [9:0] maxp_rem_q;
  logic [7:0] pulse_rem_q;
  logic [4:0] dwell_q;
  logic occ_q;
  logic green_q;
  logic tuned_q;
  logic call_q;
  logic osc_q;
  logic auto_rst_q;
  logic retune_q;

  // Diagnostic display state
  logic ind_en_q;
  logic dll_en_q;
  logic [9:0] ind_sec_q;
  logic [9:0] dll_sec_q;
  logic [7:0] peak_q;
  logic [4:0] hold_q;

  // Decoded conditions
  logic forced;
  logic sync_en;
  logic maxp_exp;
  logic ext_ok;
  logic green_fall;
  logic ind_ok;

  assign forced = (sens_q == vlct_pkg::SENS_FORCE) || (sens_q == vlct_pkg::SENS_OFF);
  assign sync_en = sync_q && (maxp_q != 10'h000);
  assign maxp_exp = (maxp_q != 10'h000) && (maxp_rem_q == 10'h000);
  assign ext_ok = (ext_q != 8'h00) && (!gate_q || i_phase_green);
  assign green_fall = green_q && !i_phase_green;
  assign ind_ok = (i_induct_uh >= vlct_pkg::IND_MIN) && (i_induct_uh <= vlct_pkg::IND_MAX);

  // Millisecond, tenth and second ticks from the system clock
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ms_cnt_q <= '0;
      tenth_cnt_q <= 7'h00;
      sec_cnt_q <= 4'h0;
      tick_ms_q <= 1'b0;
      tick_t_q <= 1'b0;
      tick_s_q <= 1'b0;
    end
    else
    begin
      tick_ms_q <= 1'b0;
      tick_t_q <= 1'b0;
      tick_s_q <= 1'b0;
      if (ms_cnt_q == MSW'(MS_CYC - 1))
      begin
        ms_cnt_q <= '0;
        tick_ms_q <= 1'b1;
        if (tenth_cnt_q == 7'(vlct_pkg::T_TENTH_MS - 1))
        begin
          tenth_cnt_q <= 7'h00;
          tick_t_q <= 1'b1;
          if (sec_cnt_q == 4'(vlct_pkg::T_SEC_TENTHS - 1))
          begin
            sec_cnt_q <= 4'h0;
            tick_s_q <= 1'b1;
          end
          else
            sec_cnt_q <= sec_cnt_q + 4'h1;
        end
        else
          tenth_cnt_q <= tenth_cnt_q + 7'h01;
      end
      else
        ms_cnt_q <= ms_cnt_q + MSW'(1);
    end
  end

  // Address phase qualifier; single zero-wait word transfers
  assign acc = i_hsel && i_htrans[1] && i_hready;
  assign wr_act = wr_q;

  // Read multiplexer, unmapped offsets read zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    unique case (i_haddr[7:0])
      vlct_pkg::A_CTRL:
      begin
        rd_d[vlct_pkg::F_SENS +: 4] = sens_q;
        rd_d[vlct_pkg::F_FREQ +: 3] = freq_q;
        rd_d[vlct_pkg::F_PULSE] = pulse_q;
        rd_d[vlct_pkg::F_GATE] = gate_q;
        rd_d[vlct_pkg::F_SYNC] = sync_en;
      end
      vlct_pkg::A_DELAY: rd_d[7:0] = delay_q;
      vlct_pkg::A_EXT: rd_d[7:0] = ext_q;
      vlct_pkg::A_MAXP: rd_d[9:0] = maxp_q;
      vlct_pkg::A_DIAG: rd_d[1:0] = {dll_en_q, ind_en_q};
      vlct_pkg::A_STAT: rd_d[23:0] = {delay_rem_q, ext_rem_q, 1'b0, tuned_q, call_q, state_q};
      vlct_pkg::A_TIMER: rd_d[9:0] = maxp_rem_q;
      vlct_pkg::A_DISP:
      begin
        // Inductance only shown while enabled and in range
        if (ind_en_q && ind_ok)
          rd_d[11:0] = i_induct_uh;
        if (dll_en_q)
          rd_d[23:16] = peak_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Bus slave, no wait state
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= acc && i_hwrite;
      if (acc)
        adr_q <= i_haddr[7:0];
      // Read data stands during the data phase
      if (acc && !i_hwrite)
        rdata_q <= rd_d;
    end
  end

  // Configuration writes in the data phase
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sens_q <= vlct_pkg::RST_SENS;
      freq_q <= vlct_pkg::RST_FREQ;
      pulse_q <= 1'b0;
      gate_q <= 1'b0;
      sync_q <= 1'b0;
      delay_q <= 8'h00;
      ext_q <= 8'h00;
      maxp_q <= 10'h000;
      cfg_rst_q <= 1'b0;
    end
    else
    begin
      cfg_rst_q <= 1'b0;
      if (wr_act && (adr_q == vlct_pkg::A_CTRL))
      begin
        // Codes above channel-off are refused, level kept
        if (i_hwdata[vlct_pkg::F_SENS +: 4] <= vlct_pkg::SENS_OFF)
          sens_q <= i_hwdata[vlct_pkg::F_SENS +: 4];
        freq_q <= i_hwdata[vlct_pkg::F_FREQ +: 3];
        pulse_q <= i_hwdata[vlct_pkg::F_PULSE];
        gate_q <= i_hwdata[vlct_pkg::F_GATE];
        sync_q <= i_hwdata[vlct_pkg::F_SYNC];
        // Changing sensitivity or frequency resets the detector
        cfg_rst_q <= (i_hwdata[vlct_pkg::F_SENS +: 4] != sens_q)
          || (i_hwdata[vlct_pkg::F_FREQ +: 3] != freq_q);
      end
      if (wr_act && (adr_q == vlct_pkg::A_DELAY))
        delay_q <= i_hwdata[7:0];
      if (wr_act && (adr_q == vlct_pkg::A_EXT))
        ext_q <= i_hwdata[7:0];
      // Limit clamps at 999 seconds, zero means off
      if (wr_act && (adr_q == vlct_pkg::A_MAXP))
        maxp_q <= (i_hwdata[9:0] > vlct_pkg::MAXP_LIM) ? vlct_pkg::MAXP_LIM
          : i_hwdata[9:0];
    end
  end

  // Call timing: delay, detect, extension, max presence, pulse
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q <= vlct_pkg::ST_IDLE;
      delay_rem_q <= 8'h00;
      ext_rem_q <= 8'h00;
      maxp_rem_q <= 10'h000;
      pulse_rem_q <= 8'h00;
      dwell_q <= 5'h00;
      occ_q <= 1'b0;
      green_q <= 1'b0;
      tuned_q <= 1'b0;
      auto_rst_q <= 1'b0;
      retune_q <= 1'b0;
    end
    else
    begin
      auto_rst_q <= 1'b0;
      retune_q <= 1'b0;
      occ_q <= i_occupied;
      green_q <= i_phase_green;
      // An empty loop re-arms detection at once
      if (!i_occupied)
      begin
        tuned_q <= 1'b0;
        dwell_q <= 5'h00;
      end
      if (tick_ms_q && (pulse_rem_q != 8'h00))
        pulse_rem_q <= pulse_rem_q - 8'h01;
      if (forced || cfg_rst_q)
      begin
        // Forced states and resets park the timing
        state_q <= vlct_pkg::ST_IDLE;
        delay_rem_q <= 8'h00;
        ext_rem_q <= 8'h00;
        maxp_rem_q <= 10'h000;
        pulse_rem_q <= 8'h00;
        if (cfg_rst_q)
        begin
          auto_rst_q <= 1'b1;
          tuned_q <= i_occupied;
        end
      end
      else if (pulse_q)
      begin
        state_q <= vlct_pkg::ST_IDLE;
        // One pulse per entering vehicle
        if (i_occupied && !occ_q && !tuned_q)
          pulse_rem_q <= vlct_pkg::PULSE_CNT;
        // Dwell beyond two seconds is tuned out
        if (i_occupied && !tuned_q && tick_t_q)
        begin
          if (dwell_q == vlct_pkg::TUNE_CNT)
          begin
            tuned_q <= 1'b1;
            retune_q <= 1'b1;
          end
          else
            dwell_q <= dwell_q + 5'h01;
        end
      end
      else
      begin
        // Presence mode: max timer runs while a call stands
        if (tick_s_q && (maxp_rem_q != 10'h000))
          maxp_rem_q <= maxp_rem_q - 10'h001;
        unique case (state_q)
          vlct_pkg::ST_IDLE:
          begin
            if (i_occupied && !tuned_q)
            begin
              if ((delay_q != 8'h00) && !i_phase_green)
              begin
                state_q <= vlct_pkg::ST_DELAY;
                delay_rem_q <= delay_q;
              end
              else
              begin
                state_q <= vlct_pkg::ST_DETECT;
                maxp_rem_q <= maxp_q;
              end
            end
          end
          vlct_pkg::ST_DELAY:
          begin
            if (i_phase_green)
            begin
              // Override aborts the delay
              delay_rem_q <= 8'h00;
              state_q <= vlct_pkg::ST_DETECT;
              maxp_rem_q <= maxp_q;
            end
            else if (!i_occupied)
            begin
              delay_rem_q <= 8'h00;
              state_q <= vlct_pkg::ST_IDLE;
            end
            else if (delay_rem_q == 8'h00)
            begin
              state_q <= vlct_pkg::ST_DETECT;
              maxp_rem_q <= maxp_q;
            end
            else if (tick_s_q)
              delay_rem_q <= delay_rem_q - 8'h01;
          end
          vlct_pkg::ST_DETECT:
          begin
            if (!i_occupied)
            begin
              if (ext_ok)
              begin
                state_q <= vlct_pkg::ST_EXTEND;
                ext_rem_q <= ext_q;
              end
              else
              begin
                state_q <= vlct_pkg::ST_IDLE;
                maxp_rem_q <= 10'h000;
              end
            end
            else if (maxp_exp)
            begin
              if (sync_en)
                state_q <= vlct_pkg::ST_WAIT;
              else
              begin
                state_q <= vlct_pkg::ST_IDLE;
                tuned_q <= 1'b1;
                auto_rst_q <= 1'b1;
              end
            end
          end
          vlct_pkg::ST_EXTEND:
          begin
            if (i_occupied)
            begin
              state_q <= vlct_pkg::ST_DETECT;
              ext_rem_q <= 8'h00;
            end
            else if ((ext_rem_q == 8'h00) || maxp_exp || (gate_q && !i_phase_green))
            begin
              // Loop is vacant: the call just drops
              state_q <= vlct_pkg::ST_IDLE;
              ext_rem_q <= 8'h00;
              maxp_rem_q <= 10'h000;
            end
            else if (tick_t_q)
              ext_rem_q <= ext_rem_q - 8'h01;
          end
          vlct_pkg::ST_WAIT:
          begin
            if (!i_occupied)
              state_q <= vlct_pkg::ST_IDLE;
            else if (green_fall && !i_loop_fail)
            begin
              // Reset lines up with the end of green
              state_q <= vlct_pkg::ST_IDLE;
              tuned_q <= 1'b1;
              auto_rst_q <= 1'b1;
            end
          end
          default: state_q <= vlct_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Output call and oscillator enable
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      call_q <= 1'b0;
      osc_q <= 1'b0;
    end
    else
    begin
      osc_q <= !forced;
      if (sens_q == vlct_pkg::SENS_FORCE)
        call_q <= 1'b1;
      else if (sens_q == vlct_pkg::SENS_OFF)
        call_q <= 1'b0;
      else if (pulse_q)
        call_q <= (pulse_rem_q != 8'h00);
      else
        call_q <= (state_q == vlct_pkg::ST_DETECT) || (state_q == vlct_pkg::ST_EXTEND)
          || (state_q == vlct_pkg::ST_WAIT);
    end
  end

  // Diagnostic displays
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ind_en_q <= 1'b0;
      dll_en_q <= 1'b0;
      ind_sec_q <= 10'h000;
      dll_sec_q <= 10'h000;
      peak_q <= 8'h00;
      hold_q <= 5'h00;
    end
    else
    begin
      // Countdown to automatic switch-off
      if (tick_s_q && ind_en_q)
      begin
        ind_sec_q <= ind_sec_q - 10'h001;
        if (ind_sec_q == 10'h001)
          ind_en_q <= 1'b0;
      end
      if (tick_s_q && dll_en_q)
      begin
        dll_sec_q <= dll_sec_q - 10'h001;
        if (dll_sec_q == 10'h001)
          dll_en_q <= 1'b0;
      end
      // Writing one starts a display and its full timeout
      if (wr_act && (adr_q == vlct_pkg::A_DIAG))
      begin
        ind_en_q <= i_hwdata[0];
        dll_en_q <= i_hwdata[1];
        ind_sec_q <= vlct_pkg::DIAG_CNT;
        dll_sec_q <= vlct_pkg::DIAG_CNT;
      end
      // Peak captured during a call, held two seconds
      if (tick_t_q && (hold_q != 5'h00))
        hold_q <= hold_q - 5'h01;
      if (dll_en_q && call_q)
      begin
        if ((i_dll_pct > peak_q) || ((hold_q == 5'h00) && !tick_t_q))
        begin
          peak_q <= i_dll_pct;
          hold_q <= vlct_pkg::PEAK_CNT;
        end
      end
    end
  end

  assign o_hrdata = rdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_call = call_q;
  assign o_osc_en = osc_q;
  assign o_sens_level = sens_q;
  assign o_freq_sel = freq_q;
  assign o_auto_reset = auto_rst_q;
  assign o_retune = retune_q;

endmodule

// ==== vlct_top_sva.sv ====
`timescale 1ns/1ps
// Port checker
module vlct_top_sva #(
  parameter int unsigned MS_CYC = 4
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_occupied,
  input wire logic i_phase_green,
  input wire logic o_call,
  input wire logic o_osc_en,
  input wire logic [3:0] o_sens_level,
  input wire logic o_auto_reset,
  input wire logic o_retune,
  input wire logic o_hreadyout,
  input wire logic o_hresp
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // Forced call: output held, oscillator stopped
  property p_force;
    o_sens_level == vlct_pkg::SENS_FORCE && $past(o_sens_level, 3) == vlct_pkg::SENS_FORCE
      |-> o_call && !o_osc_en;
  endproperty
  a_force: assert property (p_force) else $error("forced call not held");
  // Channel off: no call, oscillator stopped
  property p_off;
    o_sens_level == vlct_pkg::SENS_OFF && $past(o_sens_level, 3) == vlct_pkg::SENS_OFF
      |-> !o_call && !o_osc_en;
  endproperty
  a_off: assert property (p_off) else $error("channel off not quiet");
  // Only nine levels and two forced codes exist
  property p_range;
    o_sens_level <= 4'hA;
  endproperty
  a_range: assert property (p_range) else $error("sensitivity code out of range");
  // Entry in green calls at once
  property p_green;
    $rose(i_occupied) && i_phase_green && $past(i_phase_green) && o_osc_en && !o_auto_reset
      |-> ##[1:3] o_call;
  endproperty
  a_green: assert property (p_green) else $error("green did not override delay");
  // A call only starts for an occupied loop
  property p_rise;
    $rose(o_call) && o_sens_level <= 4'h8 |-> $past(i_occupied) || $past(i_occupied, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("call without vehicle");
  // Tune-out pulse for a dwelling vehicle
  property p_retune;
    o_retune |-> $past(i_occupied) ##1 !o_retune;
  endproperty
  a_retune: assert property (p_retune) else $error("tune-out pulse wrong");
  // Detector reset is a single-cycle pulse
  property p_rst_pulse;
    o_auto_reset |=> !o_auto_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  // A reset drops the call within three cycles
  property p_rst_drop;
    o_auto_reset && o_sens_level <= 4'h8 |-> ##[0:3] !o_call;
  endproperty
  a_rst_drop: assert property (p_rst_drop) else $error("call kept over reset");
  // Bus slave never stalls and always answers okay
  property p_bus;
    o_hreadyout && !o_hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus response not okay");

  // Main scenarios reached
  c_reset: cover property (o_auto_reset);
  c_retune: cover property (o_retune);
  c_call: cover property ($rose(o_call));
endmodule

bind vlct_top vlct_top_sva #(.MS_CYC(MS_CYC)) u_vlct_top_sva (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_occupied(i_occupied), .i_phase_green(i_phase_green),
  .o_call(o_call), .o_osc_en(o_osc_en), .o_sens_level(o_sens_level),
  .o_auto_reset(o_auto_reset), .o_retune(o_retune), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp)
);
